// ### hw/rf_front_end_config_regs.sv
// Purpose: configuration bank for receiver gain and antenna driver strength
// Assumes: state inputs come from logic on the same clock
// Notes:   read data valid only in the cycle after the read strobe
//
// Chosen here: the address-and-strobe port.
`default_nettype none

module rf_front_end_config_regs (
  // clock and reset
  input  wire logic                              clock,
  input  wire logic                              srst,
  // register port
  input  wire logic [rf_cfg_pkg::ADDR_W-1:0]     addr,
  input  wire logic [rf_cfg_pkg::DATA_W-1:0]     wr_data,
  input  wire logic                              wr_strobe,
  input  wire logic                              rd_strobe,
  output logic      [rf_cfg_pkg::DATA_W-1:0]     rd_data,
  // device state
  input  wire logic                              modulating,
  input  wire logic                              antenna_out_a_on,
  input  wire logic                              antenna_out_b_on,
  input  wire logic                              soft_power_down,
  input  wire logic                              full_depth_keying_force,
  // applied settings
  output logic      [rf_cfg_pkg::GAIN_W-1:0]     receiver_gain_sel,
  output logic      [rf_cfg_pkg::DB_W-1:0]       receiver_gain_db,
  output logic      [rf_cfg_pkg::N_W-1:0]        n_drive_applied,
  output logic                                   n_drive_active,
  output logic      [rf_cfg_pkg::P_W-1:0]        p_drive_applied
);

  // ---------------------------------------------------------------
  // gain decode
  // ---------------------------------------------------------------
  function automatic logic [rf_cfg_pkg::DB_W-1:0] gain_to_db(
    input logic [rf_cfg_pkg::GAIN_W-1:0] code
  );
    logic [rf_cfg_pkg::DB_W-1:0] db;
    db = rf_cfg_pkg::GAIN_DB_18;
    unique case (code)
      3'h0, 3'h2: db = rf_cfg_pkg::GAIN_DB_18;
      3'h1, 3'h3: db = rf_cfg_pkg::GAIN_DB_23;
      3'h4:       db = rf_cfg_pkg::GAIN_DB_33;
      3'h5:       db = rf_cfg_pkg::GAIN_DB_38;
      3'h6:       db = rf_cfg_pkg::GAIN_DB_43;
      3'h7:       db = rf_cfg_pkg::GAIN_DB_48;
    endcase
    return db;
  endfunction

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  // only writable fields are stored, so reserved bits cannot hold data
  logic [rf_cfg_pkg::GAIN_W-1:0] gain_reg;
  logic [rf_cfg_pkg::GAIN_W-1:0] gain_next;
  logic [rf_cfg_pkg::N_W-1:0]    n_idle_reg;
  logic [rf_cfg_pkg::N_W-1:0]    n_idle_next;
  logic [rf_cfg_pkg::N_W-1:0]    n_mod_reg;
  logic [rf_cfg_pkg::N_W-1:0]    n_mod_next;
  logic [rf_cfg_pkg::P_W-1:0]    p_idle_reg;
  logic [rf_cfg_pkg::P_W-1:0]    p_idle_next;
  logic [rf_cfg_pkg::P_W-1:0]    p_mod_reg;
  logic [rf_cfg_pkg::P_W-1:0]    p_mod_next;

  always_comb begin
    gain_next   = gain_reg;
    n_idle_next = n_idle_reg;
    n_mod_next  = n_mod_reg;
    p_idle_next = p_idle_reg;
    p_mod_next  = p_mod_reg;
    if (wr_strobe) begin
      unique case (addr)
        rf_cfg_pkg::OFF_RX_GAIN_CONFIG: begin
          gain_next = wr_data[rf_cfg_pkg::GAIN_LSB +: rf_cfg_pkg::GAIN_W];
        end
        rf_cfg_pkg::OFF_N_DRIVER_CONDUCTANCE: begin
          n_idle_next = wr_data[rf_cfg_pkg::N_IDLE_LSB +: rf_cfg_pkg::N_W];
          n_mod_next  = wr_data[rf_cfg_pkg::N_MOD_LSB +: rf_cfg_pkg::N_W];
        end
        rf_cfg_pkg::OFF_P_DRIVER_IDLE_COND: begin
          p_idle_next = wr_data[rf_cfg_pkg::P_LSB +: rf_cfg_pkg::P_W];
        end
        rf_cfg_pkg::OFF_P_DRIVER_MOD_COND: begin
          p_mod_next = wr_data[rf_cfg_pkg::P_LSB +: rf_cfg_pkg::P_W];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      gain_reg   <= rf_cfg_pkg::RST_RX_GAIN_CONFIG[rf_cfg_pkg::GAIN_LSB +: rf_cfg_pkg::GAIN_W];
      n_idle_reg <= rf_cfg_pkg::RST_N_DRIVER_CONDUCTANCE[rf_cfg_pkg::N_IDLE_LSB +: rf_cfg_pkg::N_W];
      n_mod_reg  <= rf_cfg_pkg::RST_N_DRIVER_CONDUCTANCE[rf_cfg_pkg::N_MOD_LSB +: rf_cfg_pkg::N_W];
      p_idle_reg <= rf_cfg_pkg::RST_P_DRIVER_IDLE_COND[rf_cfg_pkg::P_LSB +: rf_cfg_pkg::P_W];
      p_mod_reg  <= rf_cfg_pkg::RST_P_DRIVER_MOD_COND[rf_cfg_pkg::P_LSB +: rf_cfg_pkg::P_W];
    end else begin
      gain_reg   <= gain_next;
      n_idle_reg <= n_idle_next;
      n_mod_reg  <= n_mod_next;
      p_idle_reg <= p_idle_next;
      p_mod_reg  <= p_mod_next;
    end
  end

  // ---------------------------------------------------------------
  // driver selection
  // ---------------------------------------------------------------
  drive_sel_if #(.W(rf_cfg_pkg::N_W)) n_sel ();
  drive_sel_if #(.W(rf_cfg_pkg::P_W)) p_sel ();

  logic driver_on;

  always_comb begin
    driver_on           = antenna_out_a_on | antenna_out_b_on;
    n_sel.idle_strength = n_idle_reg;
    n_sel.mod_strength  = n_mod_reg;
    n_sel.modulating    = modulating;
    n_sel.enable        = driver_on;
    n_sel.power_down    = soft_power_down;
    n_sel.mod_ignore    = 1'b0;
    p_sel.idle_strength = p_idle_reg;
    p_sel.mod_strength  = p_mod_reg;
    p_sel.modulating    = modulating;
    // p-driver has no on/off gating of its own here
    p_sel.enable        = 1'b1;
    p_sel.power_down    = soft_power_down;
    p_sel.mod_ignore    = full_depth_keying_force;
  end

  strength_apply #(.W(rf_cfg_pkg::N_W)) n_apply (
    .s (n_sel)
  );

  strength_apply #(.W(rf_cfg_pkg::P_W)) p_apply (
    .s (p_sel)
  );

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  // one cycle of latency keeps every output straight from a flop
  logic [rf_cfg_pkg::GAIN_W-1:0] gain_out_reg;
  logic [rf_cfg_pkg::DB_W-1:0]   db_out_reg;
  logic [rf_cfg_pkg::DB_W-1:0]   db_out_next;
  logic [rf_cfg_pkg::N_W-1:0]    n_out_reg;
  logic                          n_active_reg;
  logic [rf_cfg_pkg::P_W-1:0]    p_out_reg;

  always_comb begin
    db_out_next = gain_to_db(gain_reg);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      gain_out_reg <= '0;
      db_out_reg   <= '0;
      n_out_reg    <= '0;
      n_active_reg <= 1'b0;
      p_out_reg    <= '0;
    end else begin
      gain_out_reg <= gain_reg;
      db_out_reg   <= db_out_next;
      n_out_reg    <= n_sel.applied;
      n_active_reg <= driver_on;
      p_out_reg    <= p_sel.applied;
    end
  end

  assign receiver_gain_sel = gain_out_reg;
  assign receiver_gain_db  = db_out_reg;
  assign n_drive_applied   = n_out_reg;
  assign n_drive_active    = n_active_reg;
  assign p_drive_applied   = p_out_reg;

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [rf_cfg_pkg::DATA_W-1:0] rd_reg;
  logic [rf_cfg_pkg::DATA_W-1:0] rd_next;

  always_comb begin
    rd_next = '0;
    if (rd_strobe) begin
      unique case (addr)
        // reserved bits come from the reset pattern, so bit 3 reads one
        rf_cfg_pkg::OFF_RX_GAIN_CONFIG: begin
          rd_next = rf_cfg_pkg::RST_RX_GAIN_CONFIG;
          rd_next[rf_cfg_pkg::GAIN_LSB +: rf_cfg_pkg::GAIN_W] = gain_reg;
        end
        rf_cfg_pkg::OFF_N_DRIVER_CONDUCTANCE: begin
          rd_next[rf_cfg_pkg::N_IDLE_LSB +: rf_cfg_pkg::N_W] = n_idle_reg;
          rd_next[rf_cfg_pkg::N_MOD_LSB +: rf_cfg_pkg::N_W]  = n_mod_reg;
        end
        rf_cfg_pkg::OFF_P_DRIVER_IDLE_COND: begin
          rd_next[rf_cfg_pkg::P_LSB +: rf_cfg_pkg::P_W] = p_idle_reg;
        end
        rf_cfg_pkg::OFF_P_DRIVER_MOD_COND: begin
          rd_next[rf_cfg_pkg::P_LSB +: rf_cfg_pkg::P_W] = p_mod_reg;
        end
        // live view of the state inputs and of what the n-driver currently gets
        rf_cfg_pkg::OFF_DRIVE_STATUS: begin
          rd_next = {modulating, driver_on, soft_power_down,
                     full_depth_keying_force, n_out_reg};
        end
        default: begin
          rd_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rd_reg <= '0;
    end else begin
      rd_reg <= rd_next;
    end
  end

  assign rd_data = rd_reg;

endmodule

`default_nettype wire

// ### hw/rf_cfg_pkg.sv
// Purpose: shared constants for the radio front end configuration bank
// Assumes: byte wide registers on a plain strobe port
// Notes:   offsets are register indices, not byte addresses
`default_nettype none

package rf_cfg_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_RX_GAIN_CONFIG        = 6'h26;
  localparam logic [ADDR_W-1:0] OFF_N_DRIVER_CONDUCTANCE  = 6'h27;
  localparam logic [ADDR_W-1:0] OFF_P_DRIVER_IDLE_COND    = 6'h28;
  localparam logic [ADDR_W-1:0] OFF_P_DRIVER_MOD_COND     = 6'h29;
  localparam logic [ADDR_W-1:0] OFF_DRIVE_STATUS          = 6'h3f;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_RX_GAIN_CONFIG        = 8'h48;
  localparam logic [DATA_W-1:0] RST_N_DRIVER_CONDUCTANCE  = 8'h88;
  localparam logic [DATA_W-1:0] RST_P_DRIVER_IDLE_COND    = 8'h20;
  localparam logic [DATA_W-1:0] RST_P_DRIVER_MOD_COND     = 8'h20;

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int unsigned GAIN_LSB     = 4;
  localparam int unsigned GAIN_W       = 3;
  localparam int unsigned N_IDLE_LSB   = 4;
  localparam int unsigned N_MOD_LSB    = 0;
  localparam int unsigned N_W          = 4;
  localparam int unsigned P_LSB        = 0;
  localparam int unsigned P_W          = 6;
  localparam int unsigned DB_W         = 6;

  // ---------------------------------------------------------------
  // receiver gain figures in dB
  // ---------------------------------------------------------------
  localparam logic [DB_W-1:0] GAIN_DB_18 = 6'h12;
  localparam logic [DB_W-1:0] GAIN_DB_23 = 6'h17;
  localparam logic [DB_W-1:0] GAIN_DB_33 = 6'h21;
  localparam logic [DB_W-1:0] GAIN_DB_38 = 6'h26;
  localparam logic [DB_W-1:0] GAIN_DB_43 = 6'h2b;
  localparam logic [DB_W-1:0] GAIN_DB_48 = 6'h30;

endpackage

`default_nettype wire

// ### hw/drive_sel_if.sv
// Purpose: carries one driver's settings and state to its selector
// Assumes: selector is purely combinational
// Notes:   width follows the conductance field of that driver
`default_nettype none

interface drive_sel_if #(
  parameter int unsigned W = 4
);
  logic [W-1:0] idle_strength;
  logic [W-1:0] mod_strength;
  logic         modulating;
  logic         enable;
  logic         power_down;
  logic         mod_ignore;
  logic [W-1:0] applied;

  modport bank (
    output idle_strength,
    output mod_strength,
    output modulating,
    output enable,
    output power_down,
    output mod_ignore,
    input  applied
  );

  modport sel (
    input  idle_strength,
    input  mod_strength,
    input  modulating,
    input  enable,
    input  power_down,
    input  mod_ignore,
    output applied
  );
endinterface

`default_nettype wire

// ### hw/strength_apply.sv
// Purpose: picks the conductance a driver really gets
// Assumes: all inputs on the system clock
// Notes:   combinational; the bank registers the result
`default_nettype none

module strength_apply #(
  parameter int unsigned W = 4
) (
  // settings and state
  drive_sel_if.sel s
);

  logic [W-1:0] pick;

  always_comb begin
    pick = s.modulating ? s.mod_strength : s.idle_strength;
    if (s.modulating && s.mod_ignore) begin
      pick = '0;
    end
    if (s.power_down) begin
      pick[W-1] = 1'b1;
    end
    // only while a driver is on
    s.applied = s.enable ? pick : '0;
  end

endmodule

`default_nettype wire

// ### tb/rf_cfg_regs_sva.sv
// Purpose: port checks for the front end config bank
// Assumes: one clock, srst synchronous active high
// Notes:   applied outputs lag state inputs by one edge and register writes by two
`default_nettype none

module rf_cfg_regs_chk (
  // clock and reset
  input wire logic                          clock,
  input wire logic                          srst,
  // register port
  input wire logic [rf_cfg_pkg::ADDR_W-1:0] addr,
  input wire logic [rf_cfg_pkg::DATA_W-1:0] wr_data,
  input wire logic                          wr_strobe,
  input wire logic                          rd_strobe,
  input wire logic [rf_cfg_pkg::DATA_W-1:0] rd_data,
  // device state
  input wire logic                          modulating,
  input wire logic                          antenna_out_a_on,
  input wire logic                          antenna_out_b_on,
  input wire logic                          soft_power_down,
  input wire logic                          full_depth_keying_force,
  // applied settings
  input wire logic [rf_cfg_pkg::GAIN_W-1:0] receiver_gain_sel,
  input wire logic [rf_cfg_pkg::DB_W-1:0]   receiver_gain_db,
  input wire logic [rf_cfg_pkg::N_W-1:0]    n_drive_applied,
  input wire logic                          n_drive_active,
  input wire logic [rf_cfg_pkg::P_W-1:0]    p_drive_applied
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  logic wr_gain;
  logic drv_on;
  assign wr_gain = wr_strobe && addr == 6'h26;
  assign drv_on  = antenna_out_a_on || antenna_out_b_on;

  function automatic logic [5:0] db_of(input logic [2:0] c);
    case (c)
      3'h4:    db_of = 6'h21;
      3'h5:    db_of = 6'h26;
      3'h6:    db_of = 6'h2b;
      3'h7:    db_of = 6'h30;
      default: db_of = c[0] ? 6'h17 : 6'h12;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  sequence s_read(a);
    rd_strobe && addr == a;
  endsequence
  // outputs of a reset edge are all zero, so skip it
  sequence s_live;
    !$past(srst);
  endsequence

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // reserved part of the gain register shows its reset pattern 0_xxx_1000 (bit 7 zero, bits 3:0 1000)
  a_gain_rsv: assert property (s_read(6'h26) |=> rd_data[7] == 1'b0
    && rd_data[3:0] == 4'h8)
    else $error("gain reserved bits not at reset pattern");
  a_p_rsv: assert property (s_read(6'h28) or s_read(6'h29) |=> rd_data[7:6] == 2'h0)
    else $error("p reserved bits not zero");
  a_gain_decode: assert property (s_live
    |-> receiver_gain_db == db_of(receiver_gain_sel))
    else $error("gain decode wrong");
  a_n_gated: assert property (!drv_on |=> n_drive_applied == 4'h0 && !n_drive_active)
    else $error("n drive not gated off");
  a_n_active: assert property (drv_on |=> n_drive_active)
    else $error("n drive not active");
  a_pd_n_msb: assert property (soft_power_down && drv_on |=> n_drive_applied[3])
    else $error("n msb not forced");
  a_pd_p_msb: assert property (soft_power_down |=> p_drive_applied[5])
    else $error("p msb not forced");
  a_force_p: assert property (modulating && full_depth_keying_force
    && !soft_power_down |=> p_drive_applied == 6'h00)
    else $error("p mod field not ignored");
  a_gain_hold: assert property (s_live ##0 !$past(srst, 2)
    ##0 $changed(receiver_gain_sel) |-> $past(wr_gain, 2))
    else $error("gain changed without write");
endmodule

bind rf_front_end_config_regs rf_cfg_regs_chk i_chk (
  .clock(clock), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
  .rd_strobe(rd_strobe), .rd_data(rd_data), .modulating(modulating),
  .antenna_out_a_on(antenna_out_a_on), .antenna_out_b_on(antenna_out_b_on),
  .soft_power_down(soft_power_down), .full_depth_keying_force(full_depth_keying_force),
  .receiver_gain_sel(receiver_gain_sel), .receiver_gain_db(receiver_gain_db),
  .n_drive_applied(n_drive_applied), .n_drive_active(n_drive_active),
  .p_drive_applied(p_drive_applied));

`default_nettype wire

// ### tb/rf_front_end_config_regs_tb.sv
// Purpose: self-checking bench for the front end config bank
// Assumes: read data stands only in the cycle after the strobe
// Notes:   monitor pops expectations in queue order
`default_nettype none

module rf_front_end_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {logic [1:0] k; logic [7:0] v;} exp_s;

  logic       clock = 1'b0;
  logic       srst = 1'b1;
  logic [5:0] addr = 6'h00;
  logic [7:0] wr_data = 8'h00;
  logic       wr_strobe = 1'b0;
  logic       rd_strobe = 1'b0;
  logic [4:0] st = 5'h00; // mod, drv a, drv b, power-down, force
  logic [7:0] rd_data;
  logic [2:0] gain_sel;
  logic [5:0] gain_db;
  logic [3:0] n_app;
  logic       n_act;
  logic [5:0] p_app;
  logic       look = 1'b0;
  logic       look_seen = 1'b0;
  logic       rd_seen = 1'b0;
  logic [7:0] rnd = 8'h0d;
  logic [7:0] sh [4];
  logic [7:0] msk [4] = '{8'h70, 8'hff, 8'h3f, 8'h3f};
  logic [7:0] rv [4] = '{8'h48, 8'h88, 8'h20, 8'h20}; // reset values
  string      nm [4] = '{"rd_data", "gain_sel n_drive", "p_drive_applied", "receiver_gain_db"};
  exp_s       exp_q[$];
  int         num_errors = 0;
  int         tests_run = 0;
  int         cycles = 0;

  always #2 clock = ~clock;

  rf_front_end_config_regs i_rf_front_end_config_regs (
    .clock(clock), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .modulating(st[4]),
    .antenna_out_a_on(st[3]), .antenna_out_b_on(st[2]), .soft_power_down(st[1]),
    .full_depth_keying_force(st[0]), .receiver_gain_sel(gain_sel),
    .receiver_gain_db(gain_db), .n_drive_applied(n_app), .n_drive_active(n_act),
    .p_drive_applied(p_app));

  // ---------------------------------------------------------------
  // reference model
  // ---------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [5:0] db_exp(input logic [2:0] c);
    logic [5:0] t [8];
    t = '{6'h12, 6'h17, 6'h12, 6'h17, 6'h21, 6'h26, 6'h2b, 6'h30};
    db_exp = t[c];
  endfunction

  function automatic logic [4:0] n_exp(input logic [7:0] r, input logic [4:0] s);
    logic [3:0] v;
    v = s[4] ? r[3:0] : r[7:4];
    v[3] = v[3] | s[1];
    n_exp = (s[3] | s[2]) ? {1'b1, v} : 5'h00;
  endfunction

  function automatic logic [5:0] p_exp(input logic [7:0] i, m, input logic [4:0] s);
    logic [5:0] v;
    v = s[4] ? (s[0] ? 6'h00 : m[5:0]) : i[5:0];
    v[5] = v[5] | s[1];
    p_exp = v;
  endfunction

  // ---------------------------------------------------------------
  // bus driver
  // ---------------------------------------------------------------
  // each step assigns every strobe once, so back to back calls are safe
  task automatic step(input logic w, r, l, input logic [5:0] a, input logic [7:0] d);
    wr_strobe <= w;
    rd_strobe <= r;
    look <= l;
    addr <= a;
    wr_data <= d;
    @(posedge clock);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [1:0] i;
    i = 2'(a - 6'h26);
    // reserved bits keep their reset pattern
    if (a >= 6'h26 && a <= 6'h29) sh[i] = (d & msk[i]) | (rv[i] & ~msk[i]);
    step(1'b1, 1'b0, 1'b0, a, d);
  endtask

  task automatic rd(input logic [5:0] a);
    logic [4:0] n;
    logic [7:0] v;
    n = n_exp(sh[1], st);
    v = (a >= 6'h26 && a <= 6'h29) ? sh[2'(a - 6'h26)] : 8'h00;
    // status view: state inputs and the applied n-drive value
    if (a == 6'h3f) v = {st[4], st[3] | st[2], st[1], st[0], n[3:0]};
    exp_q.push_back({2'h0, v});
    step(1'b0, 1'b1, 1'b0, a, 8'h00);
  endtask

  task automatic idle(input int n);
    repeat (n) step(1'b0, 1'b0, 1'b0, addr, wr_data);
  endtask

  task automatic look_outs;
    idle(2);
    exp_q.push_back({2'h1, sh[0][6:4], n_exp(sh[1], st)});
    exp_q.push_back({2'h2, 2'h0, p_exp(sh[2], sh[3], st)});
    exp_q.push_back({2'h3, 2'h0, db_exp(sh[0][6:4])});
    step(1'b0, 1'b0, 1'b1, addr, wr_data);
  endtask

  // ---------------------------------------------------------------
  // monitor
  // ---------------------------------------------------------------
  task automatic cmp(input logic [1:0] k, input logic [7:0] seen);
    exp_s e;
    tests_run++;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : {~k, ~seen};
    if (e.k !== k || e.v !== seen) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm[k], e.v, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge clock) begin
    rd_seen <= rd_strobe;
    look_seen <= look;
    cycles <= cycles + 1;
  end

  always @(negedge clock) begin
    if (rd_seen) cmp(2'h0, rd_data);
    if (look_seen) begin
      cmp(2'h1, {gain_sel, n_act, n_app});
      cmp(2'h2, {2'h0, p_app});
      cmp(2'h3, {2'h0, gain_db});
    end
    if (cycles > 4000) begin
      num_errors++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    sh = rv;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    st <= 5'h0c;
    for (logic [5:0] a = 6'h26; a <= 6'h29; a++) rd(a);
    rd(6'h10);
    look_outs();
    $display("test reset_values done");
    for (logic [5:0] a = 6'h26; a <= 6'h29; a++) wr(a, 8'hff);
    wr(6'h10, 8'hff);
    wr(6'h3f, 8'hff);
    for (logic [5:0] a = 6'h26; a <= 6'h29; a++) rd(a);
    rd(6'h10);
    repeat (4) begin
      for (logic [5:0] a = 6'h26; a <= 6'h29; a++) begin
        wr(a, rnd);
        rd(a);
        rnd = lfsr(rnd);
      end
    end
    $display("test access done");
    for (int c = 0; c < 8; c++) begin
      wr(6'h26, {rnd[7], c[2:0], rnd[3:0]});
      rnd = lfsr(rnd);
      look_outs();
    end
    $display("test gain_decode done");
    for (int s = 0; s < 32; s++) begin
      for (logic [5:0] a = 6'h27; a <= 6'h29; a++) begin
        wr(a, rnd);
        rnd = lfsr(rnd);
      end
      st <= s[4:0];
      look_outs();
      rd(6'h3f);
    end
    $display("test drive_select done");
    srst <= 1'b1;
    idle(1);
    srst <= 1'b0;
    sh = rv;
    for (logic [5:0] a = 6'h26; a <= 6'h29; a++) rd(a);
    look_outs();
    idle(2);
    $display("test mid_reset done");
    stop_test();
  end
endmodule

`default_nettype wire
